// ---- bench/afmh_host_model.sv ----
// Host model: register bus master of the frame handshake bench.
// Assumes one-cycle strobes taken on the rising clock edge.
module afmh_host_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] rdata_in,
	output logic      [7:0] addr_out,
	output logic      [7:0] wdata_out,
	output logic            wr_out,
	output logic            rd_out,
	output logic            poll_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial {addr_out, wdata_out, wr_out, rd_out, poll_out} = '0;
	// Codes 24h, 02h, 05h, other requests and busy clears all go out here
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1;
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(posedge clk_in);
		#1;
		wr_out = 1'b0;
	endtask : wr
	// Strobes end up two cycles apart, which back to back mailbox reads need
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		#1;
		addr_out = a;
		rd_out = 1'b1;
		@(posedge clk_in);
		#1;
		rd_out = 1'b0;
		d = rdata_in;
	endtask : rd
	// Polls a flag, never the code register; bounded so a dead device cannot hang us
	task poll(input logic [7:0] a, input int b, output logic ok);
		logic [7:0] d;
		ok = 1'b0;
		poll_out = 1'b1;
		for (int i = 0; i < 400 && !ok; i++) begin
			rd(a, d);
			ok = d[b];
		end
		poll_out = 1'b0;
	endtask : poll
endmodule : afmh_host_model

// ---- bench/audio_frame_mailbox_handshake_test.sv ----
// Bench of the frame handshake: host model on the registers, codec core driven here.
// Assumes the device fills and reads the mailbox from byte 0.
module audio_frame_mailbox_handshake_test;
	import afmh_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 1'b0, rst_n = 1'b0, tx_valid = 1'b0, rd_q = 1'b0, voc_c0 = 1'b1, ok;
	logic        wr, rd, poll, int_n, tx_ready, rx_valid, rx_comp;
	logic [7:0]  addr, wdata, rdata, sfb;
	logic [15:0] tx_word, rx_word;
	logic [8:0]  comp_bytes = 9'h002;
	logic [1:0]  interface_select;
	logic [7:0]  put_q[$], reg_q[$];
	logic [16:0] rx_q[$];
	int          err_total = 0, num_checks = 0;
	always #2.5 clk = ~clk;
	afmh_handshake #(.INIT_CYCLES_P(32'd20), .EXCH_CYCLES_P(32'd50)) i_afmh_handshake (
		.CLK_IN(clk), .RESET_N_IN(rst_n), .HOST_ADDR_IN(addr), .HOST_WDATA_IN(wdata),
		.HOST_WR_IN(wr), .HOST_RD_IN(rd), .HOST_RDATA_OUT(rdata), .HOST_INT_N_OUT(int_n),
		.CORE_TX_WORD_IN(tx_word), .CORE_TX_VALID_IN(tx_valid), .CORE_TX_READY_OUT(tx_ready),
		.CORE_COMP_BYTES_IN(comp_bytes), .CORE_RX_WORD_OUT(rx_word), .CORE_RX_VALID_OUT(rx_valid),
		.CORE_RX_COMP_OUT(rx_comp), .INTERFACE_SELECT_OUT(interface_select), .SFB_CFG_OUT(sfb));
	afmh_host_model i_afmh_host_model (.clk_in(clk), .rdata_in(rdata), .addr_out(addr),
		.wdata_out(wdata), .wr_out(wr), .rd_out(rd), .poll_out(poll));
	// A new word is offered only once the last was taken, with random stalls
	always @(posedge clk) begin
		if (tx_valid && tx_ready) begin
			put_q.push_back(tx_word[15:8]);
			put_q.push_back(tx_word[7:0]);
		end
		if (rst_n && (!tx_valid || tx_ready)) begin
			#1;
			tx_valid = ($urandom_range(3) != 0);
			tx_word = 16'($urandom);
		end
	end
	always @(posedge clk) begin
		if (rd_q) chk("rdata", 17'(rdata), 17'(reg_q.pop_front()));
		if (rx_valid) chk("rx", {rx_comp, rx_word}, rx_q.pop_front());
		rd_q <= rd && !poll;
	end
	// ****************************************
	// Tasks
	// ****************************************
	task chk(input string n, input logic [16:0] s, input logic [16:0] e);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task rdx(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		reg_q.push_back(e);
		i_afmh_host_model.rd(a, d);
	endtask : rdx
	task wait_dev(input logic msk);
		ok = 1'b0;
		if (msk) begin
			for (int i = 0; i < 3000 && !ok; i++) begin
				@(posedge clk);
				ok = !int_n;
			end
		end else begin
			i_afmh_host_model.poll(REG_SUMMARY, SUMMARY_DSP_INTERRUPT_FLAG_BIT, ok);
			chk("int_n", 17'(int_n), 17'h1);
		end
		chk("dev_int", 17'(ok), 17'h1);
	endtask : wait_dev
	task xch(input logic [7:0] code, input int n, input logic [7:0] hc, input logic msk);
		logic [15:0] w;
		wait_dev(msk);
		rdx(REG_SUMMARY, 8'h01);
		rdx(REG_DSP_CODE, code);
		rdx(REG_HS_STAT, 8'h06);
		i_afmh_host_model.wr(REG_HS_STAT, 8'h02);
		if (n == 0) return;
		i_afmh_host_model.wr(REG_MBOX_PTR, 8'h00);
		for (int i = 0; i < n; i++) rdx(REG_MBOX_DATA, put_q.pop_front());
		i_afmh_host_model.wr(REG_MBOX_PTR, 8'h00);
		for (int i = 0; i < n; i += 2) begin
			w = 16'($urandom);
			rx_q.push_back({hc == CODE_COMP_REQ, w});
			i_afmh_host_model.wr(REG_MBOX_DATA, w[15:8]);
			i_afmh_host_model.wr(REG_MBOX_DATA, w[7:0]);
		end
		i_afmh_host_model.wr(REG_HOST_CODE, hc);
	endtask : xch
	task frame(input logic [7:0] ctrl, input logic msk);
		i_afmh_host_model.wr(REG_MASK, {7'h0, msk});
		i_afmh_host_model.wr(REG_CTRL, ctrl);
		comp_bytes = 9'(2 * $urandom_range(128, 1));
		repeat (2) @(posedge clk);
		chk("interface_select", 17'(interface_select), 17'(ctrl[1:0]));
		if (ctrl[1:0] == INTERFACE_SELECT_SFB_HOST) begin
			chk("sfb", 17'(sfb), 17'h1f);
			rdx(REG_HS_STAT, 8'h00);
			i_afmh_host_model.poll(REG_HS_STAT, STAT_READY_BIT, ok);
		end
		i_afmh_host_model.wr(REG_HOST_CODE, 8'h11);
		rdx(REG_HS_STAT, 8'h04);
		i_afmh_host_model.wr(REG_HOST_CODE, CODE_READY);
		for (int k = 0; k < (ctrl[CTRL_PASS16_BIT] ? 2 : 1); k++) begin
			xch(voc_c0 ? CODE_VOC_A : CODE_VOC_B, !ctrl[CTRL_PASS16_BIT] ? int'(comp_bytes) :
				k == 0 ? 256 : ctrl[CTRL_INBAND_BIT] ? 80 : 64, CODE_COMP_REQ, msk);
			voc_c0 = !voc_c0;
		end
		repeat (4) xch(CODE_UNC_ACK, ctrl[CTRL_RATE16_BIT] ? 80 : 40, CODE_UNC_REQ, msk);
		xch(CODE_FINISH, 0, 8'h00, msk);
	endtask : frame
	task end_sim;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim
	initial begin
		tx_word = 16'($urandom(99848));
		repeat (20) @(posedge clk);
		chk("interface_select", 17'(interface_select), 17'(INTERFACE_SELECT_SFB_SAI));
		chk("sfb", 17'(sfb), 17'(SFB_CFG_RESET));
		#1;
		rst_n = 1'b1;
		i_afmh_host_model.poll(REG_HS_STAT, STAT_READY_BIT, ok);
		rdx(REG_CTRL, CTRL_RESET);
		rdx(REG_MASK, MASK_RESET);
		rdx(8'h7f, 8'h00);
		frame(8'h00, 1'b1);
		frame(8'h04, 1'b0);
		frame(8'h0c, 1'b1);
		frame(8'h18, 1'b1);
		i_afmh_host_model.wr(REG_SFB_CFG, 8'h05);
		rdx(REG_SFB_CFG, 8'h05);
		frame(8'h01, 1'b1);
		repeat (10) @(posedge clk);
		chk("left", 17'(rx_q.size() + reg_q.size()), 17'h0);
		end_sim;
	end
	initial begin
		repeat (80000) @(posedge clk);
		err_total++;
		end_sim;
	end
endmodule : audio_frame_mailbox_handshake_test

// ---- verilog/afmh_handshake.sv ----
// Audio frame mailbox handshake: host register port, mailbox and frame sequencer.
// Assumes the host bus strobes are synchronous one-cycle pulses on CLK_IN.
module afmh_handshake
	import afmh_pkg::*;
#(
	parameter logic [31:0] INIT_CYCLES_P = INIT_CYCLES,
	parameter logic [31:0] EXCH_CYCLES_P = EXCH_CYCLES
)(
	input  wire logic        CLK_IN,
	input  wire logic        RESET_N_IN,
	input  wire logic [7:0]  HOST_ADDR_IN,
	input  wire logic [7:0]  HOST_WDATA_IN,
	input  wire logic        HOST_WR_IN,
	input  wire logic        HOST_RD_IN,
	output logic      [7:0]  HOST_RDATA_OUT,
	output logic             HOST_INT_N_OUT,
	input  wire logic [15:0] CORE_TX_WORD_IN,
	input  wire logic        CORE_TX_VALID_IN,
	output logic             CORE_TX_READY_OUT,
	input  wire logic [8:0]  CORE_COMP_BYTES_IN,
	output logic      [15:0] CORE_RX_WORD_OUT,
	output logic             CORE_RX_VALID_OUT,
	output logic             CORE_RX_COMP_OUT,
	output logic      [1:0]  INTERFACE_SELECT_OUT,
	output logic      [7:0]  SFB_CFG_OUT
);
	// ****************************************
	// Declarations
	// ****************************************
	afmh_state_e state, next_state;
	logic [7:0]  host_code, next_host_code, dsp_code, next_dsp_code;
	logic        host_busy, next_host_busy, dsp_busy, next_dsp_busy;
	logic [7:0]  ctrl, next_ctrl, sfb_cfg, next_sfb_cfg, mask, next_mask, mbox_ptr, next_mbox_ptr;
	logic [7:0]  rdata, next_rdata;
	logic        int_n, next_int_n;
	logic [8:0]  dev_cnt, next_dev_cnt, col_cnt, next_col_cnt;
	logic [1:0]  exch, next_exch;
	logic        second, next_second, voc_toggle, next_voc_toggle, lo_phase, next_lo_phase;
	logic [7:0]  lo_hold, next_lo_hold, hi_hold, next_hi_hold;
	logic        rd_v, next_rd_v, col_hi, next_col_hi;
	logic [15:0] rx_word, next_rx_word;
	logic        rx_valid, next_rx_valid, rx_comp, next_rx_comp;
	logic [31:0] init_cnt, next_init_cnt, pace_cnt, next_pace_cnt;
	logic        dev_we, mem_we, is_put, is_get, comp, host_wr_code, ctrl_wr, pace_tick;
	logic [7:0]  dev_waddr, dev_wdata, mem_waddr, mem_wdata, mem_raddr, mem_q;
	logic [8:0]  len;
	logic [1:0]  wsel;

	assign is_put       = (state == ST_COMP_PUT) || (state == ST_UNC_PUT);
	assign is_get       = (state == ST_COMP_GET) || (state == ST_UNC_GET);
	assign comp         = (state == ST_COMP_PUT) || (state == ST_COMP_GET);
	assign len          = afmh_len(comp, ctrl[CTRL_PASS16_BIT], second, ctrl[CTRL_RATE16_BIT],
		ctrl[CTRL_INBAND_BIT], CORE_COMP_BYTES_IN);
	assign host_wr_code = HOST_WR_IN && (HOST_ADDR_IN == REG_HOST_CODE);
	assign ctrl_wr      = HOST_WR_IN && (HOST_ADDR_IN == REG_CTRL);
	assign wsel         = HOST_WDATA_IN[1:0];
	assign pace_tick    = (pace_cnt == EXCH_CYCLES_P - 32'h1);
	// Byte pairing: high byte written while the low byte waits
	assign CORE_TX_READY_OUT = is_put && !lo_phase;
	assign dev_we       = is_put && (lo_phase || CORE_TX_VALID_IN);
	assign dev_waddr    = lo_phase ? dev_cnt[7:0] + 8'h1 : dev_cnt[7:0];
	assign dev_wdata    = lo_phase ? lo_hold : CORE_TX_WORD_IN[15:8];
	// Device port wins the mailbox; the host must stay off it during a device run
	assign mem_we       = dev_we || (HOST_WR_IN && HOST_ADDR_IN == REG_MBOX_DATA);
	assign mem_waddr    = dev_we ? dev_waddr : mbox_ptr;
	assign mem_wdata    = dev_we ? dev_wdata : HOST_WDATA_IN;
	assign mem_raddr    = is_get ? dev_cnt[7:0] : mbox_ptr;

	afmh_mailbox_ram u_mbox (
		.clk_in    (CLK_IN),
		.we_in     (mem_we),
		.waddr_in  (mem_waddr),
		.wdata_in  (mem_wdata),
		.raddr_in  (mem_raddr),
		.rdata_out (mem_q)
	);

	// ****************************************
	// Host register port
	// ****************************************
	always_comb begin
		next_ctrl     = ctrl;
		next_sfb_cfg  = sfb_cfg;
		next_mask     = mask;
		next_mbox_ptr = mbox_ptr;
		next_host_code = host_code;
		next_rdata    = rdata;
		if (ctrl_wr) begin
			next_ctrl = HOST_WDATA_IN;
			if (wsel == INTERFACE_SELECT_SFB_HOST)
				next_sfb_cfg = SFB_CFG_RESET;
		end
		if (HOST_WR_IN) begin
			unique case (HOST_ADDR_IN)
				REG_MBOX_PTR:  next_mbox_ptr = HOST_WDATA_IN;
				REG_MBOX_DATA: next_mbox_ptr = mbox_ptr + 8'h1;
				REG_HOST_CODE: next_host_code = HOST_WDATA_IN;
				REG_MASK:      next_mask = HOST_WDATA_IN;
				// Overwrites are refused while the serial bus init is still running
				REG_SFB_CFG:   if (state != ST_INIT) next_sfb_cfg = HOST_WDATA_IN;
				default: ;
			endcase
		end
		if (HOST_RD_IN) begin
			unique case (HOST_ADDR_IN)
				REG_MBOX_PTR:  next_rdata = mbox_ptr;
				REG_MBOX_DATA: next_rdata = mem_q;
				REG_HOST_CODE: next_rdata = host_code;
				REG_HS_STAT:   next_rdata = {5'h0, state != ST_INIT, dsp_busy, host_busy};
				REG_DSP_CODE:  next_rdata = dsp_code;
				REG_CTRL:      next_rdata = ctrl;
				REG_SFB_CFG:   next_rdata = sfb_cfg;
				REG_MASK:      next_rdata = mask;
				REG_SUMMARY:   next_rdata = {7'h0, dsp_busy};
				default:       next_rdata = 8'h00;
			endcase
			if (HOST_ADDR_IN == REG_MBOX_DATA)
				next_mbox_ptr = mbox_ptr + 8'h1;
		end
		// Mask gates only the line, never the summary flag
		next_int_n = !(dsp_busy && mask[MASK_DSP_INTERRUPT_FLAG_BIT]);
	end

	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			ctrl      <= CTRL_RESET;
			sfb_cfg   <= SFB_CFG_RESET;
			mask      <= MASK_RESET;
			mbox_ptr  <= 8'h00;
			host_code <= 8'h00;
			rdata     <= 8'h00;
			int_n     <= 1'b1;
		end else begin
			ctrl      <= next_ctrl;
			sfb_cfg   <= next_sfb_cfg;
			mask      <= next_mask;
			mbox_ptr  <= next_mbox_ptr;
			host_code <= next_host_code;
			rdata     <= next_rdata;
			int_n     <= next_int_n;
		end
	end

	// ****************************************
	// Frame sequencer
	// ****************************************
	always_comb begin
		next_state      = state;
		next_dsp_code   = dsp_code;
		next_dsp_busy   = dsp_busy;
		next_host_busy  = host_busy;
		next_dev_cnt    = dev_cnt;
		next_col_cnt    = col_cnt;
		next_exch       = exch;
		next_second     = second;
		next_voc_toggle = voc_toggle;
		next_lo_phase   = lo_phase;
		next_lo_hold    = lo_hold;
		next_hi_hold    = hi_hold;
		next_col_hi     = col_hi;
		next_rx_word    = rx_word;
		next_rx_comp    = rx_comp;
		next_rx_valid   = 1'b0;
		next_rd_v       = 1'b0;
		next_init_cnt   = (init_cnt == 32'h0) ? 32'h0 : init_cnt - 32'h1;
		next_pace_cnt   = pace_tick ? 32'h0 : pace_cnt + 32'h1;
		// Host clears the device busy bit by writing one to it
		if (HOST_WR_IN && HOST_ADDR_IN == REG_HS_STAT && HOST_WDATA_IN[STAT_DSP_BUSY_BIT])
			next_dsp_busy = 1'b0;
		unique case (state)
			ST_INIT: if (init_cnt == 32'h0)
				next_state = (ctrl[1:0] == INTERFACE_SELECT_SFB_SAI) ? ST_IDLE : ST_FINISH;
			ST_IDLE: ;
			ST_FINISH: if (host_busy) begin
				next_host_busy = 1'b0;
				if (host_code == CODE_READY) begin
					next_state   = ST_COMP_PUT;
					next_second  = 1'b0;
					next_dev_cnt = 9'h0;
				end
			end
			ST_COMP_PUT, ST_UNC_PUT: begin
				if (lo_phase) begin
					next_lo_phase = 1'b0;
					next_dev_cnt  = dev_cnt + 9'h2;
					if (dev_cnt + 9'h2 == len) begin
						next_dsp_busy = 1'b1;
						next_dev_cnt  = 9'h0;
						if (comp) begin
							next_dsp_code   = voc_toggle ? CODE_VOC_B : CODE_VOC_A;
							next_voc_toggle = !voc_toggle;
							next_state      = ST_COMP_WAIT;
						end else begin
							next_dsp_code = CODE_UNC_ACK;
							next_state    = ST_UNC_WAIT;
						end
					end
				end else if (CORE_TX_VALID_IN) begin
					next_lo_phase = 1'b1;
					next_lo_hold  = CORE_TX_WORD_IN[7:0];
				end
			end
			ST_COMP_WAIT: if (host_busy && host_code == CODE_COMP_REQ) begin
				next_state   = ST_COMP_GET;
				next_col_cnt = 9'h0;
				next_col_hi  = 1'b1;
			end
			ST_UNC_WAIT: if (host_busy && host_code == CODE_UNC_REQ) begin
				next_state   = ST_UNC_GET;
				next_col_cnt = 9'h0;
				next_col_hi  = 1'b1;
			end
			ST_COMP_GET, ST_UNC_GET: begin
				if (dev_cnt != len) begin
					next_dev_cnt = dev_cnt + 9'h1;
					next_rd_v    = 1'b1;
				end
				if (rd_v) begin
					next_col_hi  = !col_hi;
					next_col_cnt = col_cnt + 9'h1;
					if (col_hi)
						next_hi_hold = mem_q;
					else begin
						next_rx_word  = {hi_hold, mem_q};
						// Kind travels with the word: the state has moved on by the last one
						next_rx_comp  = comp;
						next_rx_valid = 1'b1;
					end
				end
				if (rd_v && col_cnt + 9'h1 == len) begin
					next_host_busy = 1'b0;
					next_dev_cnt   = 9'h0;
					if (comp && ctrl[CTRL_PASS16_BIT] && !second) begin
						next_second = 1'b1;
						next_state  = ST_COMP_PUT;
					end else if (comp) begin
						next_exch  = 2'h0;
						next_state = ST_UNC_PACE;
					end else if (exch == LAST_UNC_EXCH) begin
						next_dsp_code = CODE_FINISH;
						next_dsp_busy = 1'b1;
						next_state    = ST_FINISH;
					end else begin
						next_exch  = exch + 2'h1;
						next_state = ST_UNC_PACE;
					end
				end
			end
			// Serial bus sets the pace; host-only mode runs as fast as the host answers
			ST_UNC_PACE: if (ctrl[1:0] != INTERFACE_SELECT_SFB_HOST || pace_tick)
				next_state = ST_UNC_PUT;
		endcase
		if (host_wr_code)
			next_host_busy = 1'b1;
		if (ctrl_wr) begin
			next_dev_cnt  = 9'h0;
			next_lo_phase = 1'b0;
			if (wsel == INTERFACE_SELECT_SFB_HOST) begin
				next_state    = ST_INIT;
				next_init_cnt = INIT_CYCLES_P - 32'h1;
			end else if (wsel == INTERFACE_SELECT_HOST_HOST)
				next_state = ST_FINISH;
			else
				next_state = ST_IDLE;
		end
	end

	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			state      <= ST_INIT;
			dsp_code   <= 8'h00;
			dsp_busy   <= 1'b0;
			host_busy  <= 1'b0;
			dev_cnt    <= 9'h0;
			col_cnt    <= 9'h0;
			exch       <= 2'h0;
			second     <= 1'b0;
			voc_toggle <= 1'b0;
			lo_phase   <= 1'b0;
			lo_hold    <= 8'h00;
			hi_hold    <= 8'h00;
			col_hi     <= 1'b1;
			rx_word    <= 16'h0000;
			rx_comp    <= 1'b0;
			rx_valid   <= 1'b0;
			rd_v       <= 1'b0;
			init_cnt   <= INIT_CYCLES_P - 32'h1;
			pace_cnt   <= 32'h0;
		end else begin
			state      <= next_state;
			dsp_code   <= next_dsp_code;
			dsp_busy   <= next_dsp_busy;
			host_busy  <= next_host_busy;
			dev_cnt    <= next_dev_cnt;
			col_cnt    <= next_col_cnt;
			exch       <= next_exch;
			second     <= next_second;
			voc_toggle <= next_voc_toggle;
			lo_phase   <= next_lo_phase;
			lo_hold    <= next_lo_hold;
			hi_hold    <= next_hi_hold;
			col_hi     <= next_col_hi;
			rx_word    <= next_rx_word;
			rx_comp    <= next_rx_comp;
			rx_valid   <= next_rx_valid;
			rd_v       <= next_rd_v;
			init_cnt   <= next_init_cnt;
			pace_cnt   <= next_pace_cnt;
		end
	end

	assign HOST_RDATA_OUT       = rdata;
	assign HOST_INT_N_OUT       = int_n;
	assign CORE_RX_WORD_OUT     = rx_word;
	assign CORE_RX_VALID_OUT    = rx_valid;
	assign CORE_RX_COMP_OUT     = rx_comp;
	assign INTERFACE_SELECT_OUT = ctrl[1:0];
	assign SFB_CFG_OUT          = sfb_cfg;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RESET_N_IN);

	a_ready_starts_frame: assert property ((state == ST_FINISH && host_busy && host_code == CODE_READY
		&& !HOST_WR_IN) |=> state == ST_COMP_PUT && !host_busy) else $error("ready code not served");
	a_comp_req_taken: assert property ((state == ST_COMP_WAIT && host_busy && host_code == CODE_COMP_REQ
		&& !HOST_WR_IN) |=> state == ST_COMP_GET) else $error("compressed request ignored");
	a_voc_code_posted: assert property ((state == ST_COMP_PUT && next_state == ST_COMP_WAIT && !HOST_WR_IN)
		|=> dsp_busy && (dsp_code == CODE_VOC_A || dsp_code == CODE_VOC_B)
		&& voc_toggle != $past(voc_toggle)) else $error("frame done code wrong");
	a_unc_code_posted: assert property ((state == ST_UNC_PUT && next_state == ST_UNC_WAIT && !HOST_WR_IN)
		|=> dsp_code == CODE_UNC_ACK && dsp_busy) else $error("uncompressed code wrong");
	a_unc_length: assert property ((state == ST_UNC_PUT && lo_phase && next_state == ST_UNC_WAIT)
		|-> dev_cnt + 9'h2 == (ctrl[CTRL_RATE16_BIT] ? 9'h050 : 9'h028)) else $error("bad packet size");
	a_finish_code: assert property ((state == ST_UNC_GET && next_state == ST_FINISH && !HOST_WR_IN)
		|=> dsp_code == CODE_FINISH && exch == 2'h3) else $error("finish code wrong");
	a_int_line_mask: assert property (##1 HOST_INT_N_OUT == !($past(dsp_busy) && $past(mask[0])))
		else $error("interrupt line not gated by mask");
	a_msb_first: assert property ((CORE_TX_READY_OUT && CORE_TX_VALID_IN && !ctrl_wr) |-> mem_we
		&& mem_wdata == CORE_TX_WORD_IN[15:8] ##1 mem_wdata == $past(CORE_TX_WORD_IN[7:0]))
		else $error("byte order wrong");
	a_pass16_twice: assert property ((state == ST_COMP_GET && next_state == ST_COMP_PUT && !ctrl_wr)
		|=> second && ctrl[CTRL_PASS16_BIT]) else $error("second run missing");
	a_sel_sfb_init: assert property ((ctrl_wr && wsel == INTERFACE_SELECT_SFB_HOST) |=> state == ST_INIT
		&& sfb_cfg == SFB_CFG_RESET) else $error("serial bus init not started");

	c_frame_start: cover property (state == ST_FINISH ##1 state == ST_COMP_PUT);
	c_fourth_exch: cover property (state == ST_UNC_GET && next_state == ST_FINISH);
	c_pass16_run: cover property (second && state == ST_COMP_WAIT);
endmodule : afmh_handshake

// ---- verilog/afmh_mailbox_ram.sv ----
// Mailbox store: 256 bytes, one write port, one read port with registered data.
// Assumes the caller arbitrates the single address of each port.
module afmh_mailbox_ram
	import afmh_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       we_in,
	input  wire logic [7:0] waddr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic [7:0] raddr_in,
	output logic      [7:0] rdata_out
);
	logic [7:0] mem [0:255];

	// No reset: contents are undefined until written, as a real mailbox RAM
	always_ff @(posedge clk_in) begin
		if (we_in)
			mem[waddr_in] <= wdata_in;
		rdata_out <= mem[raddr_in];
	end
endmodule : afmh_mailbox_ram

// ---- verilog/afmh_pkg.sv ----
// Constants, state type and helper function of the audio frame mailbox handshake.
// Assumes one 200 MHz clock shared with the host bus logic.
package afmh_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] REG_MBOX_PTR  = 8'h40;
	localparam logic [7:0] REG_MBOX_DATA = 8'h41;
	localparam logic [7:0] REG_HOST_CODE = 8'h50;
	localparam logic [7:0] REG_HS_STAT   = 8'h51;
	localparam logic [7:0] REG_DSP_CODE  = 8'h58;
	localparam logic [7:0] REG_CTRL      = 8'h60;
	localparam logic [7:0] REG_SFB_CFG   = 8'h62;
	localparam logic [7:0] REG_MASK      = 8'h74;
	localparam logic [7:0] REG_SUMMARY   = 8'h75;
	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam int STAT_HOST_BUSY_BIT = 0;
	localparam int STAT_DSP_BUSY_BIT  = 1;
	localparam int STAT_READY_BIT     = 2;
	localparam int CTRL_RATE16_BIT    = 2;
	localparam int CTRL_PASS16_BIT    = 3;
	localparam int CTRL_INBAND_BIT    = 4;
	localparam int SUMMARY_DSP_INTERRUPT_FLAG_BIT   = 0;
	localparam int MASK_DSP_INTERRUPT_FLAG_BIT      = 0;
	localparam logic [1:0] INTERFACE_SELECT_HOST_HOST = 2'h0;
	localparam logic [1:0] INTERFACE_SELECT_SFB_HOST  = 2'h1;
	localparam logic [1:0] INTERFACE_SELECT_SFB_SAI   = 2'h2;
	localparam logic [7:0] CTRL_RESET     = 8'h02;
	localparam logic [7:0] SFB_CFG_RESET  = 8'h1f;
	localparam logic [7:0] MASK_RESET     = 8'h00;
	// ****************************************
	// Interrupt codes and sizes
	// ****************************************
	localparam logic [7:0] CODE_VOC_A    = 8'hc0;
	localparam logic [7:0] CODE_VOC_B    = 8'h80;
	localparam logic [7:0] CODE_COMP_REQ = 8'h24;
	localparam logic [7:0] CODE_UNC_ACK  = 8'h03;
	localparam logic [7:0] CODE_UNC_REQ  = 8'h02;
	localparam logic [7:0] CODE_FINISH   = 8'h04;
	localparam logic [7:0] CODE_READY    = 8'h05;
	localparam logic [8:0] UNC_BYTES_8K   = 9'h028;
	localparam logic [8:0] UNC_BYTES_16K  = 9'h050;
	localparam logic [8:0] PASS16_FIRST   = 9'h100;
	localparam logic [8:0] PASS16_OUTBAND = 9'h040;
	localparam logic [8:0] PASS16_INBAND  = 9'h050;
	localparam logic [1:0] LAST_UNC_EXCH  = 2'h3;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ        = 200;
	localparam int INIT_TIME_US   = 10000;
	localparam int EXCH_TIME_US   = 2500;
	localparam int INIT_CYCLES    = INIT_TIME_US * CLK_MHZ;
	localparam int EXCH_CYCLES    = EXCH_TIME_US * CLK_MHZ;

	typedef enum logic [3:0] {
		ST_INIT, ST_IDLE, ST_FINISH, ST_COMP_PUT, ST_COMP_WAIT, ST_COMP_GET,
		ST_UNC_PACE, ST_UNC_PUT, ST_UNC_WAIT, ST_UNC_GET
	} afmh_state_e;

	// Bytes moved per direction by one exchange
	function automatic logic [8:0] afmh_len(input logic comp, input logic pass16, input logic second,
		input logic rate16, input logic inband, input logic [8:0] comp_bytes);
		if (!comp)
			afmh_len = rate16 ? UNC_BYTES_16K : UNC_BYTES_8K;
		else if (pass16)
			afmh_len = !second ? PASS16_FIRST : (inband ? PASS16_INBAND : PASS16_OUTBAND);
		else
			afmh_len = comp_bytes;
	endfunction : afmh_len
endpackage : afmh_pkg
